// *** fmsp_consts.vh ***
// Constants for the four-mode serial port: register addresses, field positions,
// mode codes and timing counts.
// Assumes inclusion by bare name from the serial port design files.
`ifndef FMSP_CONSTS_VH
`define FMSP_CONSTS_VH

// Register addresses on the core special-function bus
`define FMSP_ADDR_CTRL     8'h98
`define FMSP_ADDR_BUF      8'h99
`define FMSP_CTRL_RESET    8'h00
`define FMSP_RDATA_RESET   8'h00
`define FMSP_BUF_RESET     8'h00

// Control register fields
`define FMSP_MODE_HI       7
`define FMSP_MODE_LO       6
`define FMSP_MP_EN         5
`define FMSP_RX_ALLOW      4
`define FMSP_TX_NINTH      3
`define FMSP_RX_NINTH      2
`define FMSP_TX_DONE       1
`define FMSP_RX_DONE       0

// Mode codes {mode_sel_hi, mode_sel_lo}
`define FMSP_MODE_SHIFT    2'h0
`define FMSP_MODE_ASYNC8   2'h1
`define FMSP_MODE_FIX9     2'h2
`define FMSP_MODE_VAR9     2'h3

// Fixed-rate prescaler terminal counts (oversample tick every 4 or 2 clocks)
`define FMSP_PRE_SLOW      2'h3
`define FMSP_PRE_FAST      2'h1

// Oversampling: 16 ticks per bit, sample at tick 7
`define FMSP_OS_MID        4'h7
`define FMSP_OS_LAST       4'hf

// Bit indices within a frame
`define FMSP_TX_STOP8      4'h9
`define FMSP_TX_STOP9      4'ha
`define FMSP_RX_FINAL8     4'h8
`define FMSP_RX_FINAL9     4'h9
`define FMSP_M0_LAST_BIT   3'h7

`endif

// *** fmsp_core.v ***
// Four-mode serial port: control register, data buffer, shift-register mode
// and 8/9-bit asynchronous transmitter and receiver.
// Assumes core bus strobes and serial input are synchronous to clk; timer
// overflow ticks come from outside as one-cycle pulses.
`include "fmsp_consts.vh"
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Two mode bits select shift, 8-bit async, fixed 9-bit or variable 9-bit mode.
// - Shift mode clock runs at core clock divided by two.
// - Fixed 9-bit mode bit rate is clock/64, or clock/32 with rate double.
// - 8-bit mode with filter set needs a valid stop bit for receive flag.
// - 9-bit modes with filter set drop frames whose ninth bit is 0.
// - Reception only while receive-allow is set; clearing it stops reception.
// - 9-bit modes send the transmit ninth bit as bit nine.
// - Received ninth bit (or 8-bit stop bit) goes to the receive ninth field.
// - Transmit flag sets after bit eight (shift) or at stop start; software clears.
// - Receive flag sets after bit eight (shift) or mid stop bit; software clears.
// - Shift mode moves eight bits LSB first on data pin, clock on transmit pin.
// - Shift mode receive starts from idle when receive-allow is 1, receive flag 0 and no buffer write.
// - 8-bit frame is start 0, eight data LSB first, stop 1.
// - Writing the buffer starts a transmission in every mode.
// - 8-bit mode loads 1 as ninth shift position, sent as stop bit.
// - Async reception starts on falling edge, checks start bit, shifts eight bits (nine in 9-bit modes).
// - Frame accepted only if receive flag 0 and filter off or bit set.
// - 9-bit frame is start, eight data, ninth bit, stop: eleven bits.
// - 9-bit transmit starts shifting at the next bit tick after the write.
// - Variable modes time bits from timer 1 or timer 2 overflows.
// - Variable 9-bit mode frames like fixed 9-bit with variable timing.
// - Received byte is held while the next one is being received.
// - Buffer write loads transmit side; read returns separate receive register.
// - Control register clears to zero at reset.
// - Timer 2 select bits steer each direction to timer 2 overflows in the variable modes.
module fmsp_core (
  input  wire       clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       rate_double_bit,
  input  wire       tx_timer2_select,
  input  wire       rx_timer2_select,
  input  wire       timer1_ovf,
  input  wire       timer2_ovf,
  input  wire       rxd_in,
  output reg        rxd_out,
  output reg        rxd_oe,
  output reg        txd_out,
  output reg        tx_done_flag,
  output reg        rx_done_flag
);

  localparam TX_IDLE  = 3'h1;
  localparam TX_WAIT  = 3'h2;
  localparam TX_SHIFT = 3'h4;
  localparam RX_IDLE  = 3'h1;
  localparam RX_START = 3'h2;
  localparam RX_DATA  = 3'h4;
  localparam M0_IDLE  = 3'h1;
  localparam M0_TX    = 3'h2;
  localparam M0_RX    = 3'h4;

  reg  [7:0]  ctrl_reg;
  reg  [7:0]  ctrl_next;
  reg  [7:0]  rx_buf_reg;
  reg  [2:0]  tx_state_reg;
  reg  [10:0] tx_sh_reg;
  reg  [3:0]  tx_idx_reg;
  reg  [3:0]  tx_os_reg;
  reg         tx_line_reg;
  reg  [2:0]  rx_state_reg;
  reg  [3:0]  rx_os_reg;
  reg  [3:0]  rx_idx_reg;
  reg  [8:0]  rx_sh_reg;
  reg         rxd_prev_reg;
  reg  [2:0]  m0_state_reg;
  reg         m0_phase_reg;
  reg  [2:0]  m0_cnt_reg;
  reg  [7:0]  m0_sh_reg;
  reg         ti_set;
  reg         ri_set;
  reg         rx_load;
  reg         rb8_load;
  reg  [7:0]  rx_load_data;

  wire [1:0]  mode     = {ctrl_reg[`FMSP_MODE_HI], ctrl_reg[`FMSP_MODE_LO]};
  wire        is_m0    = (mode == `FMSP_MODE_SHIFT);
  wire        is_m1    = (mode == `FMSP_MODE_ASYNC8);
  wire        ren      = ctrl_reg[`FMSP_RX_ALLOW];
  wire        ri       = ctrl_reg[`FMSP_RX_DONE];
  wire        ctrl_wr  = sfr_wr & (sfr_addr == `FMSP_ADDR_CTRL);
  wire        buf_wr   = sfr_wr & (sfr_addr == `FMSP_ADDR_BUF);
  wire        tx_x16;
  wire        rx_x16;
  wire        tx_bit   = tx_x16 & (tx_os_reg == `FMSP_OS_LAST);
  wire [3:0]  tx_stop  = is_m1 ? `FMSP_TX_STOP8 : `FMSP_TX_STOP9;
  wire [3:0]  rx_final = is_m1 ? `FMSP_RX_FINAL8 : `FMSP_RX_FINAL9;
  wire        rx_mid   = rx_x16 & (rx_os_reg == `FMSP_OS_MID);
  // 8-bit mode keeps the stop bit as bit nine; 9-bit modes keep the ninth bit
  wire [8:0]  rx_cap   = is_m1 ? {rxd_in, rx_sh_reg[8:1]} : rx_sh_reg;
  wire        rx_ok    = ~ri & (~ctrl_reg[`FMSP_MP_EN] | rx_cap[8]);

  fmsp_rate_tick u_tx_tick (
    .clk             (clk),
    .resetn          (resetn),
    .ce              (ce),
    .mode            (mode),
    .rate_double_bit (rate_double_bit),
    .timer2_select   (tx_timer2_select),
    .timer1_ovf      (timer1_ovf),
    .timer2_ovf      (timer2_ovf),
    .tick            (tx_x16)
  );

  fmsp_rate_tick u_rx_tick (
    .clk             (clk),
    .resetn          (resetn),
    .ce              (ce),
    .mode            (mode),
    .rate_double_bit (rate_double_bit),
    .timer2_select   (rx_timer2_select),
    .timer1_ovf      (timer1_ovf),
    .timer2_ovf      (timer2_ovf),
    .tick            (rx_x16)
  );

  // Flag and load events from the three engines
  always @* begin
    ti_set       = 1'b0;
    ri_set       = 1'b0;
    rx_load      = 1'b0;
    rb8_load     = 1'b0;
    rx_load_data = rx_cap[7:0];
    if (tx_state_reg == TX_SHIFT && tx_bit && tx_idx_reg == tx_stop)
      ti_set = 1'b1;
    if (rx_state_reg == RX_DATA && rx_mid && rx_idx_reg == rx_final && rx_ok) begin
      ri_set   = 1'b1;
      rx_load  = 1'b1;
      rb8_load = 1'b1;
    end
    if (m0_state_reg != M0_IDLE && m0_phase_reg && m0_cnt_reg == `FMSP_M0_LAST_BIT) begin
      if (m0_state_reg == M0_TX) begin
        ti_set = 1'b1;
      end else begin
        ri_set       = 1'b1;
        rx_load      = 1'b1;
        rx_load_data = {rxd_in, m0_sh_reg[7:1]};
      end
    end
  end

  // Hardware set wins over a software write in the same cycle
  always @* begin
    ctrl_next = ctrl_wr ? sfr_wdata : ctrl_reg;
    if (ti_set)
      ctrl_next[`FMSP_TX_DONE] = 1'b1;
    if (ri_set)
      ctrl_next[`FMSP_RX_DONE] = 1'b1;
    if (rb8_load)
      ctrl_next[`FMSP_RX_NINTH] = rx_cap[8];
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= `FMSP_CTRL_RESET;
      rx_buf_reg   <= `FMSP_BUF_RESET;
      sfr_rdata    <= `FMSP_RDATA_RESET;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      txd_out      <= 1'b1;
    end else if (ce) begin
      ctrl_reg     <= ctrl_next;
      tx_done_flag <= ctrl_next[`FMSP_TX_DONE];
      rx_done_flag <= ctrl_next[`FMSP_RX_DONE];
      if (rx_load)
        rx_buf_reg <= rx_load_data;
      if (sfr_rd) begin
        if (sfr_addr == `FMSP_ADDR_CTRL)
          sfr_rdata <= ctrl_reg;
        else if (sfr_addr == `FMSP_ADDR_BUF)
          sfr_rdata <= rx_buf_reg;
        else
          sfr_rdata <= `FMSP_RDATA_RESET;
      end
      // Shift clock falls as each data bit is launched and rises mid-bit, so both sides sample a stable bit
      txd_out <= is_m0 ? ((m0_state_reg == M0_IDLE) | m0_phase_reg) : tx_line_reg;
    end
  end

  // Asynchronous transmitter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg    <= 11'h7ff;
      tx_idx_reg   <= 4'h0;
      tx_os_reg    <= 4'h0;
      tx_line_reg  <= 1'b1;
    end else if (ce) begin
      if (tx_x16)
        tx_os_reg <= tx_os_reg + 4'h1;
      case (tx_state_reg)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (buf_wr && !is_m0) begin
            // Stop, ninth, data, start: for 8-bit, for 9-bit
            tx_sh_reg    <= {1'b1, (is_m1 ? 1'b1 : ctrl_reg[`FMSP_TX_NINTH]), sfr_wdata, 1'b0};
            tx_state_reg <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_bit) begin
            tx_line_reg  <= tx_sh_reg[0];
            tx_sh_reg    <= {1'b1, tx_sh_reg[10:1]};
            tx_idx_reg   <= 4'h1;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_bit) begin
            if (tx_idx_reg == tx_stop + 4'h1) begin
              tx_line_reg  <= 1'b1;
              tx_state_reg <= TX_IDLE;
            end else begin
              tx_line_reg <= tx_sh_reg[0];
              tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
              tx_idx_reg  <= tx_idx_reg + 4'h1;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Asynchronous receiver, 16x oversampled
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= 9'h000;
      rxd_prev_reg <= 1'b1;
    end else if (ce) begin
      rxd_prev_reg <= rxd_in;
      if (rx_x16)
        rx_os_reg <= rx_os_reg + 4'h1;
      case (rx_state_reg)
        RX_IDLE: begin
          rx_os_reg <= 4'h0;
          if (ren && !is_m0 && rxd_prev_reg && !rxd_in)
            rx_state_reg <= RX_START;
        end
        RX_START: begin
          if (!ren || is_m0)
            rx_state_reg <= RX_IDLE;
          else if (rx_mid) begin
            rx_idx_reg   <= 4'h0;
            rx_state_reg <= rxd_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (!ren || is_m0)
            rx_state_reg <= RX_IDLE;
          else if (rx_mid) begin
            if (rx_idx_reg == rx_final)
              rx_state_reg <= RX_IDLE;
            else begin
              rx_sh_reg  <= {rxd_in, rx_sh_reg[8:1]};
              rx_idx_reg <= rx_idx_reg + 4'h1;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Shift-register mode engine: clock on transmit pin, data on receive pin
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m0_state_reg <= M0_IDLE;
      m0_phase_reg <= 1'b0;
      m0_cnt_reg   <= 3'h0;
      m0_sh_reg    <= 8'h00;
      rxd_out      <= 1'b1;
      rxd_oe       <= 1'b0;
    end else if (ce) begin
      case (m0_state_reg)
        M0_IDLE: begin
          m0_phase_reg <= 1'b0;
          m0_cnt_reg   <= 3'h0;
          rxd_oe       <= 1'b0;
          if (is_m0 && buf_wr) begin
            m0_sh_reg    <= sfr_wdata;
            m0_state_reg <= M0_TX;
          end else if (is_m0 && ren && !ri)
            m0_state_reg <= M0_RX;
        end
        M0_TX, M0_RX: begin
          // Clock toggles every cycle: shift rate is clock/2
          m0_phase_reg <= ~m0_phase_reg;
          if (!m0_phase_reg) begin
            if (m0_state_reg == M0_TX) begin
              rxd_out <= m0_sh_reg[0];
              rxd_oe  <= 1'b1;
            end
          end else begin
            if (m0_state_reg == M0_TX)
              m0_sh_reg <= {1'b1, m0_sh_reg[7:1]};
            else
              m0_sh_reg <= {rxd_in, m0_sh_reg[7:1]};
            m0_cnt_reg <= m0_cnt_reg + 3'h1;
            if (m0_cnt_reg == `FMSP_M0_LAST_BIT || !is_m0 || (m0_state_reg == M0_RX && !ren))
              m0_state_reg <= M0_IDLE;
          end
        end
        default: m0_state_reg <= M0_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** fmsp_core_chk.sv ***
// Port assertions for the four-mode serial port core.
// Assumes one clock domain with an active-low asynchronous reset.
`include "fmsp_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module fmsp_core_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       rxd_out,
  input wire logic       rxd_oe,
  input wire logic       txd_out,
  input wire logic       tx_done_flag,
  input wire logic       rx_done_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire ctl_wr = ce && sfr_wr && sfr_addr == `FMSP_ADDR_CTRL;
  wire rd_map = sfr_addr == `FMSP_ADDR_CTRL || sfr_addr == `FMSP_ADDR_BUF;

  property p_reset_idle; $rose(resetn) |-> txd_out && !rxd_oe && !tx_done_flag && !rx_done_flag; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("idle state wrong after reset");
  property p_rd_unmapped; ce && sfr_rd && !rd_map |=> sfr_rdata == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_flags; ce && sfr_rd && sfr_addr == `FMSP_ADDR_CTRL |=> sfr_rdata[1:0] == $past({tx_done_flag, rx_done_flag}); endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("control read flags differ");
  property p_rdata_hold; !(ce && sfr_rd) |=> $stable(sfr_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_tx_sticky; tx_done_flag && !ctl_wr |=> tx_done_flag; endproperty
  a_tx_sticky: assert property (p_tx_sticky) else $error("transmit flag cleared by hardware");
  property p_rx_sticky; rx_done_flag && !ctl_wr |=> rx_done_flag; endproperty
  a_rx_sticky: assert property (p_rx_sticky) else $error("receive flag cleared by hardware");
  property p_m0_clk; rxd_oe && !txd_out |=> txd_out; endproperty
  a_m0_clk: assert property (p_m0_clk) else $error("shift clock low too long");
  property p_m0_hold; rxd_oe && !txd_out |=> $stable(rxd_out); endproperty
  a_m0_hold: assert property (p_m0_hold) else $error("shift data changed mid bit");
  property p_m0_len; $rose(rxd_oe) |-> rxd_oe[*8]; endproperty
  a_m0_len: assert property (p_m0_len) else $error("shift drive too short");
  property p_tx_stop; $rose(tx_done_flag) && !rxd_oe |=> txd_out; endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("stop bit not driven at flag");
endmodule
`default_nettype wire

// *** fmsp_line_model.sv ***
// Remote serial device: sends frames on the receive line, captures transmit frames.
// Assumes bit lengths in core clocks come from the bench per direction and a line idling at mark (1).
`timescale 1ns/10ps
`default_nettype none
module fmsp_line_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx_len,
  input  wire logic [7:0] rx_len,
  input  wire logic       txd,
  input  wire logic       dat,
  input  wire logic       oe,
  output var  logic       line,
  output var  logic       got,
  output var  logic [8:0] got_data
);
  initial begin
    line = 1'b1;
    got = 1'b0;
    got_data = 9'h000;
  end
  // Start 0, data LSB first, ninth bit or stop, stop, then idle
  task automatic send(input logic [7:0] d, input logic mark);
    logic [10:0] f;
    f = {1'b1, mark, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (rx_len) @(posedge clk);
    end
  endtask
  // Mid-bit capture of eight data bits and the ninth or stop bit
  always begin
    logic [8:0] s;
    @(posedge clk);
    if (mode != 2'h0 && txd === 1'b0) begin
      repeat (tx_len / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (tx_len) @(posedge clk);
        s[i] = txd;
      end
      got <= 1'b1;
      got_data <= s;
      @(posedge clk);
      got <= 1'b0;
    end else if (mode == 2'h0 && txd === 1'b0 && oe === 1'b1) begin
      // Shift peripheral: one data bit per clock period, taken while the shift clock is low
      s[8] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        s[i] = dat;
        repeat (2) @(posedge clk);
      end
      got <= 1'b1;
      got_data <= s;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** fmsp_rate_tick.v ***
// Oversample tick generator for one direction of the serial port.
// Assumes timer overflow inputs are one-cycle pulses synchronous to clk.
`include "fmsp_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module fmsp_rate_tick (
  input  wire       clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire [1:0] mode,
  input  wire       rate_double_bit,
  input  wire       timer2_select,
  input  wire       timer1_ovf,
  input  wire       timer2_ovf,
  output reg        tick
);

  reg  [1:0] pre_reg;
  reg        t1_half_reg;
  wire [1:0] pre_last = rate_double_bit ? `FMSP_PRE_FAST : `FMSP_PRE_SLOW;
  wire       fixed    = (mode == `FMSP_MODE_FIX9);
  wire       t1_tick  = timer1_ovf & (rate_double_bit | t1_half_reg);
  reg        tick_next;

  always @* begin
    if (fixed)
      tick_next = (pre_reg == pre_last);
    else if (timer2_select)
      tick_next = timer2_ovf;
    else
      tick_next = t1_tick;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg     <= 2'h0;
      t1_half_reg <= 1'b0;
      tick        <= 1'b0;
    end else if (ce) begin
      pre_reg <= (pre_reg == pre_last) ? 2'h0 : pre_reg + 2'h1;
      if (timer1_ovf)
        t1_half_reg <= ~t1_half_reg;
      tick <= tick_next & (mode != `FMSP_MODE_SHIFT);
    end
  end

endmodule

`default_nettype wire

// *** test_fmsp_core.sv ***
// Self-checking bench for the serial port core against a remote line model.
// Assumes the checker and line model are compiled first.
`include "fmsp_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module test_fmsp_core;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       tx_sel = 1'b0;
  logic       rx_sel = 1'b0;
  logic       t1_ovf = 1'b0;
  logic       t2_ovf = 1'b0;
  logic [1:0] lmode = 2'h0;
  logic       rd_d1 = 1'b0;
  logic       rdbl = 1'b1;
  logic [1:0] ovf_cnt = 2'h0;
  logic [7:0] tx_len = 8'h20;
  logic [7:0] rx_len = 8'h20;
  logic [7:0] sfr_rdata;
  logic       rxd_in, rxd_out, rxd_oe, txd_out, tx_done_flag, rx_done_flag, line, got;
  logic [8:0] got_data;
  logic [8:0] exp_q[$];
  int         seed = 32'h67374b56;
  int         miscompares = 0;
  int         checks = 0;

  always #2.5 clk = ~clk;
  // Timer 1 overflows every other clock, timer 2 every third, so the two sources give different bit lengths
  always @(posedge clk) begin
    t1_ovf <= ~t1_ovf;
    ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
    t2_ovf <= (ovf_cnt == 2'h0);
    rd_d1 <= sfr_rd;
  end
  assign rxd_in = rxd_oe ? rxd_out : line;

  fmsp_core u_dut (.clk(clk), .resetn(resetn), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rate_double_bit(rdbl),
    .tx_timer2_select(tx_sel), .rx_timer2_select(rx_sel), .timer1_ovf(t1_ovf), .timer2_ovf(t2_ovf),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag));
  fmsp_line_model u_line (.clk(clk), .mode(lmode), .tx_len(tx_len), .rx_len(rx_len), .txd(txd_out),
    .dat(rxd_in), .oe(rxd_oe), .line(line), .got(got), .got_data(got_data));

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic lim(input int i);
    if (i >= 4000) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 4000 && exp_q.size() != 0; i++) @(posedge clk);
    lim(i);
  endtask
  task automatic wt(input logic tx);
    int i;
    for (i = 0; i < 4000 && (tx ? tx_done_flag : rx_done_flag) !== 1'b1; i++) @(posedge clk);
    lim(i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    sfr_rd <= 1'b0;
    drain();
  endtask

  // Oldest note is compared when read data or a captured frame appears
  always @(negedge clk)
    if (rd_d1 || got) begin
      if (exp_q.size() == 0) chk("queue", 9'h1ff, 9'h000);
      else chk(rd_d1 ? "rdata" : "frame", rd_d1 ? {1'b0, sfr_rdata} : got_data, exp_q.pop_front());
    end

  initial begin
    logic [7:0] c, d;
    logic [31:0] r;
    logic [2:0] k;
    logic       n;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(`FMSP_ADDR_CTRL, 9'h000);
    rd(8'h5a, 9'h000);
    for (k = 3'h1; k < 3'h4; k++) begin
      c = {k[1:0], 6'h18};
      r = $random(seed);
      tx_sel <= r[0];
      rx_sel <= r[1];
      rdbl <= (k == 3'h1);
      lmode <= k[1:0];
      // Timer 2 gives 48 clocks a bit, timer 1 32 with rate double or 64 without; fixed mode is 64
      tx_len <= (k == 3'h2 || (!r[0] && k == 3'h3)) ? 8'h40 : r[0] ? 8'h30 : 8'h20;
      rx_len <= (k == 3'h2 || (!r[1] && k == 3'h3)) ? 8'h40 : r[1] ? 8'h30 : 8'h20;
      wr(`FMSP_ADDR_CTRL, c);
      d = r[15:8];
      exp_q.push_back({1'b1, d});
      wr(`FMSP_ADDR_BUF, d);
      wt(1'b1);
      drain();
      wr(`FMSP_ADDR_CTRL, c);
      d = r[23:16];
      n = r[24];
      u_line.send(d, n);
      wt(1'b0);
      rd(`FMSP_ADDR_BUF, {1'b0, d});
      rd(`FMSP_ADDR_CTRL, {1'b0, c | {5'h00, n, 2'h1}});
      wr(`FMSP_ADDR_CTRL, c | 8'h20);
      u_line.send(~d, 1'b0);
      repeat (40) @(posedge clk);
      chk("rx_done", {8'h00, rx_done_flag}, 9'h000);
      u_line.send(d, 1'b1);
      wt(1'b0);
      rd(`FMSP_ADDR_BUF, {1'b0, d});
    end
    lmode <= 2'h0;
    wr(`FMSP_ADDR_CTRL, 8'h00);
    exp_q.push_back({1'b0, d});
    wr(`FMSP_ADDR_BUF, d);
    wt(1'b1);
    drain();
    wr(`FMSP_ADDR_CTRL, 8'h10);
    wt(1'b0);
    rd(`FMSP_ADDR_BUF, 9'h0ff);
    final_report();
  end
endmodule

bind fmsp_core fmsp_core_chk u_chk (.clk(clk), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
  .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag));
`default_nettype wire
